// ==== pmv_port_ctrl_regs.sv ====
// per-port mirror, vlan and flow control registers with apb access
//
// Summary of operation
// - A port whose mirror-destination bit is one also transmits every packet marked as monitored, except packets it received itself and dropped packets.
// - Receive mirroring marks each packet received on the port and copies it to the mirror port.
// - Transmit mirroring marks each packet sent on the port and copies it to the mirror port.
// - Double tagging adds the ingress port default tag to every packet, tagged or not.
// - Membership bit 2 stands for port 3, bit 1 for port 2 and bit 0 for port 1; one includes.
// - Packets from a port go only to egress ports inside that port's membership or, as mirror copies, to the mirror port.
// - Ingress filtering drops packets whose vlan table membership leaves out the ingress port.
// - The discard bit drops packets whose vlan id differs from the port default vlan id.
// - Forced flow control turns flow control on regardless of the negotiated result.
// - On port 3 the forced bit does nothing and a global control bit governs flow control.
// - The forced flow-control reset value of ports 1 and 2 comes from each port's strap.
// - The back-pressure bit enables half-duplex back pressure on the port.
// - Every port's back-pressure reset value comes from the shared back-pressure strap.
// - The default tag holds priority, cfi and a 12-bit vlan id split over two registers.
//
// Local design decision: the APB slave port.
`timescale 1ns/1ps
module pmv_port_ctrl_regs (
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // strap pins
    input  wire logic        strap_force_fc_p1,
    input  wire logic        strap_force_fc_p2,
    input  wire logic        strap_backpressure_on,
    input  wire logic        strap_member_p1_to_p3,
    input  wire logic        strap_member_p1_to_p2,
    input  wire logic        strap_member_p2_to_p3,
    input  wire logic        strap_member_p2_to_p1,
    input  wire logic        strap_member_p3_to_p2,
    input  wire logic        strap_member_p3_to_p1,
    // link status from the mac side
    input  wire logic [2:0]  an_flow_ctrl_ok,
    input  wire logic        global_fc_p3,
    // packet descriptor
    input  wire logic        pkt_valid,
    input  wire logic [1:0]  pkt_port,
    input  wire logic [2:0]  pkt_dest,
    input  wire logic [11:0] pkt_vid,
    input  wire logic [2:0]  pkt_vlan_member,
    // per-port configuration out
    output logic [2:0]       sniffer_port,
    output logic [2:0]       rx_sniff,
    output logic [2:0]       tx_sniff,
    output logic [2:0]       double_tag,
    output logic [8:0]       vlan_member,
    output logic [2:0]       ingress_filter,
    output logic [2:0]       discard_non_port_default_vlan_id,
    output logic [2:0]       flow_ctrl_on,
    output logic [2:0]       backpressure_on,
    output logic [47:0]      default_tag,
    output logic [35:0]      port_default_vlan_id,
    // forwarding decision
    output logic             fwd_valid,
    output logic [2:0]       fwd_mask,
    output logic             fwd_drop,
    output logic             fwd_monitored,
    output logic             fwd_add_tag,
    output logic [15:0]      fwd_tag
);
    localparam int NP = pmv_pkg::NPORT;

    function automatic logic addr_hit(input logic [7:0] a);
        addr_hit = (a[1:0] == pmv_pkg::ALIGN_OK) &&
                   (a[7:6] >= pmv_pkg::PORT_FIRST) && (a[7:6] <= pmv_pkg::PORT_LAST) &&
                   (a[5:2] >= pmv_pkg::REG_CTRL1) && (a[5:2] <= pmv_pkg::REG_TAG_LO);
    endfunction

    // strap synchroniser, layout fixed by the assign below
    logic [8:0] strap_raw;
    logic [8:0] strap_s1_ff;
    logic [8:0] strap_s2_ff;
    logic [2:0] strap_mem [0:NP-1];
    logic [2:0] strap_fc;
    logic       strap_bp;

    logic [1:0] init_cnt_ff;
    logic [1:0] nxt_init_cnt;
    logic       strap_load;
    logic       init_done;

    logic [7:0] ctrl1_ff  [0:NP-1];
    logic [7:0] ctrl2_ff  [0:NP-1];
    logic [7:0] tag_hi_ff [0:NP-1];
    logic [7:0] tag_lo_ff [0:NP-1];
    logic [2:0] fc_on_ff;
    logic [2:0] nxt_fc_on;

    logic        pready_ff;
    logic        pslverr_ff;
    logic [31:0] prdata_ff;
    logic        take;
    logic        done;
    logic        wr_en;
    logic [1:0]  acc_port;
    logic [3:0]  acc_reg;
    logic [1:0]  acc_pidx;
    logic        hit;
    logic [7:0]  rd_byte;
    logic [7:0]  wr_byte;

    assign strap_raw = {strap_member_p3_to_p1, strap_member_p3_to_p2,
                        strap_member_p2_to_p1, strap_member_p2_to_p3,
                        strap_member_p1_to_p2, strap_member_p1_to_p3,
                        strap_backpressure_on, strap_force_fc_p2, strap_force_fc_p1};

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            strap_s1_ff <= 9'h000;
            strap_s2_ff <= 9'h000;
        end else begin
            strap_s1_ff <= strap_raw;
            strap_s2_ff <= strap_s1_ff;
        end
    end

    // membership straps, own bit always one
    assign strap_mem[0] = {strap_s2_ff[3], strap_s2_ff[4], 1'b1};
    assign strap_mem[1] = {strap_s2_ff[5], 1'b1, strap_s2_ff[6]};
    assign strap_mem[2] = {1'b1, strap_s2_ff[7], strap_s2_ff[8]};
    // port 3 has no forced flow-control strap
    assign strap_fc     = {1'b0, strap_s2_ff[1], strap_s2_ff[0]};
    assign strap_bp     = strap_s2_ff[2];

    // straps cannot be captured under async reset; they load just after release
    assign strap_load   = (init_cnt_ff == pmv_pkg::INIT_LOAD_CNT);
    assign init_done    = (init_cnt_ff == pmv_pkg::INIT_DONE_CNT);
    assign nxt_init_cnt = init_done ? init_cnt_ff : init_cnt_ff + 2'h1;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            init_cnt_ff <= 2'h0;
        end else begin
            init_cnt_ff <= nxt_init_cnt;
        end
    end

    // apb decode; ready is withheld until straps are in so no write races the load
    assign acc_port = paddr[7:6];
    assign acc_reg  = paddr[5:2];
    assign acc_pidx = acc_port - 2'h1;
    assign hit      = addr_hit(paddr);
    assign take     = psel & ~pready_ff & init_done;
    assign done     = psel & penable & pready_ff;
    assign wr_en    = done & pwrite & ~pslverr_ff & pstrb[0];
    assign wr_byte  = pwdata[pmv_pkg::REG_W-1:0];

    assign rd_byte = ~hit ? 8'h00 :
                     (acc_reg == pmv_pkg::REG_CTRL1)  ? ctrl1_ff[acc_pidx] :
                     (acc_reg == pmv_pkg::REG_CTRL2)  ? (ctrl2_ff[acc_pidx] & pmv_pkg::CTRL2_MASK) :
                     (acc_reg == pmv_pkg::REG_TAG_HI) ? tag_hi_ff[acc_pidx] :
                     tag_lo_ff[acc_pidx];

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= 32'h0000_0000;
        end else if (take) begin
            pready_ff  <= 1'b1;
            pslverr_ff <= ~hit;
            prdata_ff  <= pwrite ? 32'h0000_0000 : {24'h00_0000, rd_byte};
        end else if (done) begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < NP; gi++) begin : g_port
            localparam logic [1:0] PNUM = 2'(gi + 1);
            localparam logic [7:0] C1_RST = pmv_pkg::CTRL1_RST | 8'(pmv_pkg::OWN_BIT << gi);
            logic       sel_p;
            logic       wr_c1;
            logic       wr_c2;
            logic       wr_th;
            logic       wr_tl;
            logic [7:0] ld_c2;
            logic [7:0] nxt_c1;
            logic [7:0] nxt_c2;
            logic [7:0] nxt_th;
            logic [7:0] nxt_tl;

            assign sel_p = wr_en & (acc_port == PNUM);
            assign wr_c1 = sel_p & (acc_reg == pmv_pkg::REG_CTRL1);
            assign wr_c2 = sel_p & (acc_reg == pmv_pkg::REG_CTRL2);
            assign wr_th = sel_p & (acc_reg == pmv_pkg::REG_TAG_HI);
            assign wr_tl = sel_p & (acc_reg == pmv_pkg::REG_TAG_LO);

            assign ld_c2  = (ctrl2_ff[gi] & ~(pmv_pkg::FC_MASK | pmv_pkg::BP_MASK)) |
                            (strap_fc[gi] ? pmv_pkg::FC_MASK : 8'h00) |
                            (strap_bp ? pmv_pkg::BP_MASK : 8'h00);
            assign nxt_c1 = strap_load ? {ctrl1_ff[gi][7:3], strap_mem[gi]} :
                            wr_c1 ? wr_byte : ctrl1_ff[gi];
            // reserved and out-of-scope bits of the second register stay zero
            assign nxt_c2 = strap_load ? ld_c2 :
                            wr_c2 ? (wr_byte & pmv_pkg::CTRL2_MASK) : ctrl2_ff[gi];
            assign nxt_th = wr_th ? wr_byte : tag_hi_ff[gi];
            assign nxt_tl = wr_tl ? wr_byte : tag_lo_ff[gi];

            always_ff @(posedge core_clk or negedge rst_n) begin
                if (!rst_n) begin
                    ctrl1_ff[gi]  <= C1_RST;
                    ctrl2_ff[gi]  <= pmv_pkg::CTRL2_RST;
                    tag_hi_ff[gi] <= pmv_pkg::TAG_HI_RST;
                    tag_lo_ff[gi] <= pmv_pkg::TAG_LO_RST;
                end else begin
                    ctrl1_ff[gi]  <= nxt_c1;
                    ctrl2_ff[gi]  <= nxt_c2;
                    tag_hi_ff[gi] <= nxt_th;
                    tag_lo_ff[gi] <= nxt_tl;
                end
            end

            assign sniffer_port[gi]     = ctrl1_ff[gi][pmv_pkg::B_SNIFFER];
            assign rx_sniff[gi]         = ctrl1_ff[gi][pmv_pkg::B_RX_SNIFF];
            assign tx_sniff[gi]         = ctrl1_ff[gi][pmv_pkg::B_TX_SNIFF];
            assign double_tag[gi]       = ctrl1_ff[gi][pmv_pkg::B_DBL_TAG];
            assign vlan_member[3*gi +: 3] = ctrl1_ff[gi][pmv_pkg::MEM_HI:pmv_pkg::MEM_LO];
            assign ingress_filter[gi]   = ctrl2_ff[gi][pmv_pkg::B_IN_FILT];
            assign discard_non_port_default_vlan_id[gi] = ctrl2_ff[gi][pmv_pkg::B_DISC_NPVID];
            assign backpressure_on[gi]  = ctrl2_ff[gi][pmv_pkg::B_BACKPRES];
            assign default_tag[16*gi +: 16] = {tag_hi_ff[gi], tag_lo_ff[gi]};
            assign port_default_vlan_id[12*gi +: 12] =
                {tag_hi_ff[gi][3:0], tag_lo_ff[gi]};
        end
    endgenerate

    // registered so the output never glitches on a negotiation change
    assign nxt_fc_on = {global_fc_p3,
                        ctrl2_ff[1][pmv_pkg::B_FORCE_FC] | an_flow_ctrl_ok[1],
                        ctrl2_ff[0][pmv_pkg::B_FORCE_FC] | an_flow_ctrl_ok[0]};

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            fc_on_ff <= 3'h0;
        end else begin
            fc_on_ff <= nxt_fc_on;
        end
    end

    assign flow_ctrl_on = fc_on_ff;
    assign prdata       = prdata_ff;
    assign pready       = pready_ff;
    assign pslverr      = pslverr_ff;

    // several mirror ports are tolerated; each one other than the ingress port gets the copy
    pmv_fwd_filter u_fwd (
        .core_clk        (core_clk),
        .rst_n           (rst_n),
        .cfg_sniffer     (sniffer_port),
        .cfg_rx_sniff    (rx_sniff),
        .cfg_tx_sniff    (tx_sniff),
        .cfg_dbl_tag     (double_tag),
        .cfg_member      (vlan_member),
        .cfg_in_filt     (ingress_filter),
        .cfg_disc_npvid  (discard_non_port_default_vlan_id),
        .cfg_def_tag     (default_tag),
        .pkt_valid       (pkt_valid),
        .pkt_port        (pkt_port),
        .pkt_dest        (pkt_dest),
        .pkt_vid         (pkt_vid),
        .pkt_vlan_member (pkt_vlan_member),
        .fwd_valid       (fwd_valid),
        .fwd_mask        (fwd_mask),
        .fwd_drop        (fwd_drop),
        .fwd_monitored   (fwd_monitored),
        .fwd_add_tag     (fwd_add_tag),
        .fwd_tag         (fwd_tag)
    );
endmodule

// ==== pmv_pkg.sv ====
// shared constants for the port mirror, vlan and flow control register bank
package pmv_pkg;
    localparam int NPORT  = 3;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int REG_W  = 8;
    localparam int TAG_W  = 16;
    localparam int VID_W  = 12;
    localparam int MEM_W  = 3 * NPORT;

    // register index = {port number, register number}; byte address is four times it
    localparam logic [5:0] IDX_P1_CTRL1  = 6'h11;
    localparam logic [5:0] IDX_P1_CTRL2  = 6'h12;
    localparam logic [5:0] IDX_P1_TAG_HI = 6'h13;
    localparam logic [5:0] IDX_P1_TAG_LO = 6'h14;
    localparam logic [5:0] IDX_P2_CTRL1  = 6'h21;
    localparam logic [5:0] IDX_P2_CTRL2  = 6'h22;
    localparam logic [5:0] IDX_P2_TAG_HI = 6'h23;
    localparam logic [5:0] IDX_P2_TAG_LO = 6'h24;
    localparam logic [5:0] IDX_P3_CTRL1  = 6'h31;
    localparam logic [5:0] IDX_P3_CTRL2  = 6'h32;
    localparam logic [5:0] IDX_P3_TAG_HI = 6'h33;
    localparam logic [5:0] IDX_P3_TAG_LO = 6'h34;
    localparam logic [1:0] PORT_FIRST    = 2'h1;
    localparam logic [1:0] PORT_LAST     = 2'h3;
    localparam logic [3:0] REG_CTRL1     = 4'h1;
    localparam logic [3:0] REG_CTRL2     = 4'h2;
    localparam logic [3:0] REG_TAG_HI    = 4'h3;
    localparam logic [3:0] REG_TAG_LO    = 4'h4;
    localparam logic [1:0] ALIGN_OK      = 2'h0;

    // first control register fields
    localparam int B_SNIFFER = 7;
    localparam int B_RX_SNIFF = 6;
    localparam int B_TX_SNIFF = 5;
    localparam int B_DBL_TAG = 4;
    localparam int MEM_HI = 2;
    localparam int MEM_LO = 0;
    // second control register fields
    localparam int B_IN_FILT = 6;
    localparam int B_DISC_NPVID = 5;
    localparam int B_FORCE_FC = 4;
    localparam int B_BACKPRES = 3;
    localparam logic [7:0] FC_MASK    = 8'h10;
    localparam logic [7:0] BP_MASK    = 8'h08;
    localparam logic [7:0] CTRL2_MASK = 8'h78;

    localparam logic [7:0] CTRL1_RST  = 8'h00;
    localparam logic [7:0] CTRL2_RST  = 8'h00;
    localparam logic [7:0] TAG_HI_RST = 8'h00;
    localparam logic [7:0] TAG_LO_RST = 8'h01;
    localparam logic [7:0] OWN_BIT    = 8'h01;

    // two cycles fill the strap synchroniser, straps load on the third
    localparam logic [1:0] INIT_LOAD_CNT = 2'h2;
    localparam logic [1:0] INIT_DONE_CNT = 2'h3;
endpackage

// ==== pmv_fwd_filter.sv ====
// forwarding filter: membership, vlan drop, mirroring and double tagging
`timescale 1ns/1ps
module pmv_fwd_filter (
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    // per-port configuration
    input  wire logic [2:0]  cfg_sniffer,
    input  wire logic [2:0]  cfg_rx_sniff,
    input  wire logic [2:0]  cfg_tx_sniff,
    input  wire logic [2:0]  cfg_dbl_tag,
    input  wire logic [8:0]  cfg_member,
    input  wire logic [2:0]  cfg_in_filt,
    input  wire logic [2:0]  cfg_disc_npvid,
    input  wire logic [47:0] cfg_def_tag,
    // packet descriptor
    input  wire logic        pkt_valid,
    input  wire logic [1:0]  pkt_port,
    input  wire logic [2:0]  pkt_dest,
    input  wire logic [11:0] pkt_vid,
    input  wire logic [2:0]  pkt_vlan_member,
    // forwarding decision
    output logic             fwd_valid,
    output logic [2:0]       fwd_mask,
    output logic             fwd_drop,
    output logic             fwd_monitored,
    output logic             fwd_add_tag,
    output logic [15:0]      fwd_tag
);
    function automatic logic pick_bit(input logic [2:0] v, input logic [1:0] p);
        pick_bit = (p < pmv_pkg::PORT_LAST) ? v[p] : 1'b0;
    endfunction

    function automatic logic [15:0] pick_tag(input logic [47:0] t, input logic [1:0] p);
        case (p)
            2'h0: pick_tag = t[15:0];
            2'h1: pick_tag = t[31:16];
            2'h2: pick_tag = t[47:32];
            default: pick_tag = 16'h0000;
        endcase
    endfunction

    function automatic logic [2:0] pick_mem(input logic [8:0] m, input logic [1:0] p);
        case (p)
            2'h0: pick_mem = m[2:0];
            2'h1: pick_mem = m[5:3];
            2'h2: pick_mem = m[8:6];
            default: pick_mem = 3'h0;
        endcase
    endfunction

    logic [2:0]  ing_oh;
    logic [2:0]  ing_member;
    logic [15:0] ing_tag;
    logic        filt_drop;
    logic        disc_drop;
    logic [2:0]  egress;
    logic        monitored;
    logic [2:0]  mirror_mask;
    logic        fwd_valid_ff;
    logic [2:0]  fwd_mask_ff;
    logic        fwd_drop_ff;
    logic        fwd_mon_ff;
    logic        fwd_add_tag_ff;
    logic [15:0] fwd_tag_ff;

    assign ing_oh     = 3'h1 << pkt_port;
    assign ing_member = pick_mem(cfg_member, pkt_port);
    assign ing_tag    = pick_tag(cfg_def_tag, pkt_port);
    assign filt_drop  = pick_bit(cfg_in_filt, pkt_port) & ~|(pkt_vlan_member & ing_oh);
    assign disc_drop  = pick_bit(cfg_disc_npvid, pkt_port) &
                        (pkt_vid != ing_tag[pmv_pkg::VID_W-1:0]);
    assign egress     = pkt_dest & ing_member & ~ing_oh;
    // mark the packet; the sniffer then gets a copy
    assign monitored  = pick_bit(cfg_rx_sniff, pkt_port) | (|(egress & cfg_tx_sniff));
    assign mirror_mask = monitored ? (cfg_sniffer & ~ing_oh) : 3'h0;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            fwd_valid_ff   <= 1'b0;
            fwd_mask_ff    <= 3'h0;
            fwd_drop_ff    <= 1'b0;
            fwd_mon_ff     <= 1'b0;
            fwd_add_tag_ff <= 1'b0;
            fwd_tag_ff     <= 16'h0000;
        end else begin
            fwd_valid_ff   <= pkt_valid;
            fwd_mask_ff    <= (filt_drop | disc_drop) ? 3'h0 : (egress | mirror_mask);
            fwd_drop_ff    <= filt_drop | disc_drop;
            fwd_mon_ff     <= monitored;
            fwd_add_tag_ff <= pick_bit(cfg_dbl_tag, pkt_port);
            fwd_tag_ff     <= ing_tag;
        end
    end

    assign fwd_valid     = fwd_valid_ff;
    assign fwd_mask      = fwd_mask_ff;
    assign fwd_drop      = fwd_drop_ff;
    assign fwd_monitored = fwd_mon_ff;
    assign fwd_add_tag   = fwd_add_tag_ff;
    assign fwd_tag       = fwd_tag_ff;
endmodule

// ==== pmv_port_ctrl_regs_sva.sv ====
// checker for the port control register bank, bound to its top module
`timescale 1ns/1ps
module pmv_port_ctrl_regs_chk (
    // clock and reset
    input wire logic        core_clk,
    input wire logic        rst_n,
    // apb
    input wire logic        psel,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // flow control
    input wire logic [2:0]  an_flow_ctrl_ok,
    input wire logic        global_fc_p3,
    input wire logic [2:0]  flow_ctrl_on,
    // forwarding
    input wire logic        pkt_valid,
    input wire logic [1:0]  pkt_port,
    input wire logic [2:0]  pkt_dest,
    input wire logic [2:0]  sniffer_port,
    input wire logic        fwd_valid,
    input wire logic [2:0]  fwd_mask,
    input wire logic        fwd_drop
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready held longer than one cycle");
    a_ready_bound: assert property ($rose(psel) |-> ##[1:5] pready)
        else $error("apb request not answered in time");
    a_err_unaligned: assert property (psel && pready && paddr[1:0] != 2'h0 |-> pslverr)
        else $error("unaligned access not refused");
    a_err_reads_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
        else $error("refused read returned data");
    a_fwd_follows: assert property ($past(rst_n) |-> fwd_valid == $past(pkt_valid))
        else $error("forward decision not one cycle after descriptor");
    a_mask_in_scope: assert property (
        fwd_valid |-> (fwd_mask & ~($past(pkt_dest) | $past(sniffer_port))) == 3'h0)
        else $error("egress outside destination or sniffer ports");
    a_no_echo_port: assert property (
        fwd_valid && $past(pkt_port) != 2'h3 |-> fwd_mask[$past(pkt_port)] == 1'b0)
        else $error("packet sent back to its ingress port");
    a_drop_empty: assert property (fwd_valid && fwd_drop |-> fwd_mask == 3'h0)
        else $error("dropped packet still has egress ports");
    a_p3_flow_glob: assert property ($past(rst_n) |-> flow_ctrl_on[2] == $past(global_fc_p3))
        else $error("port 3 flow control not from global control");
    a_an_flow_on: assert property (
        $past(rst_n) |-> (~flow_ctrl_on & $past(an_flow_ctrl_ok) & 3'h3) == 3'h0)
        else $error("negotiated flow control not applied");

    c_write_done: cover property (psel && pwrite && pready && !pslverr);
    c_refused: cover property (pready && pslverr);
    c_drop: cover property (fwd_valid && fwd_drop);
endmodule

bind pmv_port_ctrl_regs pmv_port_ctrl_regs_chk pmv_port_ctrl_regs_chk_i (
    .core_clk, .rst_n, .psel, .pwrite, .paddr, .prdata, .pready, .pslverr,
    .an_flow_ctrl_ok, .global_fc_p3, .flow_ctrl_on, .pkt_valid, .pkt_port, .pkt_dest,
    .sniffer_port, .fwd_valid, .fwd_mask, .fwd_drop
);

// ==== pmv_port_ctrl_regs_tb.sv ====
// self-checking bench for the port control register bank
`timescale 1ns/1ps
module pmv_port_ctrl_regs_tb;
    logic core_clk, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata;
    logic [3:0] pstrb = 4'hF;
    logic pready, pslverr, global_fc_p3 = 1'b0, pkt_valid = 1'b0;
    logic [8:0] straps = 9'h0; // {fc1, fc2, bp, m13, m12, m23, m21, m32, m31}
    logic [2:0] an_flow_ctrl_ok = 3'h0, pkt_dest = 3'h0, pkt_vlan_member = 3'h0;
    logic [1:0] pkt_port = 2'h0;
    logic [11:0] pkt_vid = 12'h0;
    logic [2:0] flow_ctrl_on, backpressure_on, fwd_mask;
    logic [35:0] port_default_vlan_id;
    logic fwd_valid, fwd_drop, fwd_monitored, fwd_add_tag;
    logic [15:0] fwd_tag;
    logic [2:0] sniffer_port, rx_sniff, tx_sniff, double_tag, ingress_filter, discard_non_port_default_vlan_id;
    logic [8:0] vlan_member;
    logic [47:0] default_tag;
    int fail_count = 0, num_checks = 0;

    pmv_port_ctrl_regs pmv_port_ctrl_regs_i (
        .core_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
        .strap_force_fc_p1(straps[8]), .strap_force_fc_p2(straps[7]), .strap_backpressure_on(straps[6]),
        .strap_member_p1_to_p3(straps[5]), .strap_member_p1_to_p2(straps[4]),
        .strap_member_p2_to_p3(straps[3]), .strap_member_p2_to_p1(straps[2]),
        .strap_member_p3_to_p2(straps[1]), .strap_member_p3_to_p1(straps[0]),
        .an_flow_ctrl_ok, .global_fc_p3, .pkt_valid, .pkt_port, .pkt_dest, .pkt_vid, .pkt_vlan_member,
        .sniffer_port, .rx_sniff, .tx_sniff, .double_tag, .vlan_member, .ingress_filter,
        .discard_non_port_default_vlan_id, .flow_ctrl_on, .backpressure_on, .default_tag, .port_default_vlan_id,
        .fwd_valid, .fwd_mask, .fwd_drop, .fwd_monitored, .fwd_add_tag, .fwd_tag
    );

    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    task automatic summarize;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %0t %s got %h expected %h", $time, m, got, exp);
        end
    endtask

    // setup, then access until pready; released only after the sampling edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d,
                       output logic [31:0] r, output logic e);
        int n;
        n = 0;
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        r = prdata;
        e = pslverr;
        chk(32'(n < 20), 32'h1, "apb answer");
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
        chk(32'(e), 32'h0, "write error");
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] x);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 8'h00, r, e);
        chk(32'(e), 32'h0, "read error");
        chk(r, {24'h0, x}, "read data");
    endtask

    task automatic bad(input logic [7:0] a);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, 8'hFF, r, e);
        chk(32'(e), 32'h1, "write not refused");
        apb(1'b0, a, 8'h00, r, e);
        chk(32'(e), 32'h1, "read not refused");
        chk(r, 32'h0, "refused read data");
    endtask

    // straps are only seen through reset, so each reset checks a full set
    task automatic t_reset(input logic [8:0] s);
        @(posedge core_clk);
        rst_n <= 1'b0;
        straps <= s;
        repeat (10) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (5) @(posedge core_clk);
        rd(8'h44, {5'h0, s[5], s[4], 1'b1});
        rd(8'h84, {5'h0, s[3], 1'b1, s[2]});
        rd(8'hC4, {5'h0, 1'b1, s[1], s[0]});
        rd(8'h48, {3'h0, s[8], s[6], 3'h0});
        rd(8'h88, {3'h0, s[7], s[6], 3'h0});
        rd(8'hC8, {4'h0, s[6], 3'h0});
        rd(8'h8C, 8'h00);
        rd(8'hD0, 8'h01);
        chk(32'(backpressure_on), {29'h0, {3{s[6]}}}, "back pressure");
        chk(32'(vlan_member), {23'h0, 1'b1, s[1], s[0], s[3], 1'b1, s[2], s[5], s[4], 1'b1}, "membership");
    endtask

    task automatic t_regs;
        wr(8'hC4, 8'hAA);
        rd(8'hC4, 8'hAA);
        wr(8'h88, 8'hFF);
        rd(8'h88, 8'h78);
        pstrb <= 4'h0;
        wr(8'h88, 8'h00);
        pstrb <= 4'hF;
        rd(8'h88, 8'h78);
        bad(8'h00);
        bad(8'h45);
        bad(8'h54);
        // port 2 filters and forces flow control otherwise, skewing later scenarios
        wr(8'h88, 8'h00);
    endtask

    task automatic t_flow;
        wr(8'h48, 8'h10);
        wr(8'hC8, 8'h10);
        repeat (2) @(posedge core_clk);
        chk(32'(flow_ctrl_on), 32'h1, "forced flow");
        wr(8'h48, 8'h00);
        an_flow_ctrl_ok <= 3'h2;
        global_fc_p3 <= 1'b1;
        repeat (2) @(posedge core_clk);
        chk(32'(flow_ctrl_on), 32'h6, "negotiated flow");
    endtask

    task automatic pkt(input logic [1:0] pt, input logic [2:0] d, input logic [11:0] v,
                       input logic [2:0] vm, input logic [2:0] em, input logic ed);
        @(posedge core_clk);
        pkt_valid <= 1'b1;
        pkt_port <= pt;
        pkt_dest <= d;
        pkt_vid <= v;
        pkt_vlan_member <= vm;
        @(posedge core_clk);
        pkt_valid <= 1'b0;
        @(negedge core_clk);
        chk(32'(fwd_valid), 32'h1, "fwd valid");
        chk(32'(fwd_mask), 32'(em), "fwd mask");
        chk(32'(fwd_drop), 32'(ed), "fwd drop");
    endtask

    task automatic t_fwd;
        wr(8'h44, 8'h75);
        wr(8'h84, 8'h87);
        wr(8'hC4, 8'h07);
        wr(8'h4C, 8'hA1);
        wr(8'h50, 8'h05);
        @(negedge core_clk);
        chk(32'(port_default_vlan_id[11:0]), 32'h105, "default vid");
        chk(32'(default_tag[15:0]), 32'h0000_A105, "default tag");
        chk({sniffer_port, rx_sniff, tx_sniff, double_tag, 20'h0}, 32'h4490_0000, "mirror cfg");
        pkt(2'h0, 3'h6, 12'h105, 3'h7, 3'h6, 1'b0);
        chk(32'(fwd_monitored), 32'h1, "rx monitored");
        chk({15'h0, fwd_add_tag, fwd_tag}, 32'h1A105, "double tag");
        pkt(2'h2, 3'h1, 12'h105, 3'h7, 3'h3, 1'b0);
        chk(32'(fwd_add_tag), 32'h0, "no extra tag");
        pkt(2'h1, 3'h4, 12'h105, 3'h7, 3'h4, 1'b0);
        wr(8'h48, 8'h40);
        pkt(2'h0, 3'h4, 12'h105, 3'h6, 3'h0, 1'b1);
        pkt(2'h0, 3'h4, 12'h105, 3'h1, 3'h6, 1'b0);
        wr(8'h48, 8'h20);
        pkt(2'h0, 3'h4, 12'h106, 3'h6, 3'h0, 1'b1);
        pkt(2'h0, 3'h4, 12'h105, 3'h6, 3'h6, 1'b0);
        chk(32'({ingress_filter, discard_non_port_default_vlan_id}), 32'h1, "filter cfg");
    endtask

    initial begin
        repeat (20000) @(posedge core_clk);
        fail_count++;
        summarize();
    end

    initial begin
        t_reset(9'h15A);
        t_regs();
        t_flow();
        t_fwd();
        t_reset(9'h0A5);
        summarize();
    end
endmodule
